// ---- hdl/reset_interrupt_vectoring_config.sv ----
// Reset sequencing, program counter vectoring, return stack and option word decoding.
// Assumes Avalon-MM master on ref_clk; brownout and pin inputs arrive asynchronously.
//
// Contract
// [RULE1] Any reset loads PC with 0000H first
// [RULE2] Power-on, watchdog, brownout each force reset sequence
// [RULE3] Powerdown and timeout flags show reset kind
// [RULE4] Interrupt pushes PC, jumps to 0004H
// [RULE5] All interrupt sources share one vector
// [RULE6] Only PC saved on interrupt entry
// [RULE7] Return stack holds eight entries
// [RULE8] PC spans 8K words, 0000H to 1FFFH
// [RULE9] Option selects 8MHz or 16MHz oscillator
// [RULE10] Option enables or disables whole watchdog
// [RULE11] Protected code reads back as garbage
// [RULE12] Option selects 1.8V, 2.0V, 2.6V brownout
// [RULE13] Option dedicates or releases programming pins
// [RULE14] Option routes USART to port C or A
// [RULE15] Option routes capture/PWM to port A or B; code routes it to neither when USART is also on port A
// [RULE16] Only programmer reaches the option word
// [RULE17] Options latched during reset, held until next
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module reset_interrupt_vectoring_config (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        wdtTimeout,
  input  wire logic                        brownoutTrip,
  input  wire logic                        sleepEntry,
  input  wire logic                        wdtClear,
  input  wire reset_vector_pkg::core_cmd_t coreCmd,
  input  wire logic                        intRequest,
  output logic [12:0]                      pc,
  output logic                             coreHold,
  output logic                             intAccept,
  output reset_vector_pkg::options_t       options,
  output logic                             progPinsReleased,
  input  wire logic                        progWrite,
  input  wire logic [15:0]                 progWdata,
  output logic [15:0]                      progRdata,
  input  wire logic                        progFlashRead,
  input  wire logic [15:0]                 flashRdata,
  output logic [15:0]                      progFlashData,
  input  wire logic                        usartTx,
  output logic                             usartRx,
  input  wire logic [1:0]                  pwmOut,
  input  wire logic                        portaBit4In,
  input  wire logic                        portcBit1In,
  output reset_vector_pkg::pins_t          pinDrive,
  output reset_vector_pkg::pins_t          pinEnable,
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             irq
);

  reset_vector_pkg::seq_state_t state;
  reset_vector_pkg::seq_state_t next_state;
  logic [15:0] optionCell;
  logic [2:0]  syncFirst;
  logic [2:0]  syncSecond;
  logic        brownoutSync;
  logic        wdtFire;
  logic        running;
  logic        intTake;
  logic        intEnable;
  logic        timeoutFlag;
  logic        powerdownFlag;
  logic [2:0]  resetCause;
  logic [12:0] stackMem [reset_vector_pkg::STACK_DEPTH];
  logic [2:0]  stackPtr;
  logic [3:0]  stackDepth;
  logic        doPush;
  logic        doPop;
  logic [12:0] pushValue;
  logic [12:0] popValue;
  logic [3:0]  events;
  logic [3:0]  irqStatus;
  logic [3:0]  irqMask;
  logic        busAck;
  logic        busFirst;
  logic        busWrite;
  logic [31:0] readMux;
  logic [15:0] scramble;

  // Two-stage synchronisers for brownout comparator and pin inputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      syncFirst  <= 3'h0;
      syncSecond <= 3'h0;
    end else begin
      syncFirst  <= {brownoutTrip, portaBit4In, portcBit1In};
      syncSecond <= syncFirst;
    end
  end
  assign brownoutSync = syncSecond[2];

  // Watchdog only acts when enabled by option
  assign wdtFire = wdtTimeout & options.wdtEnable & running; // see [RULE10]
  assign running = (state == reset_vector_pkg::ST_RUN);

  // Reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      reset_vector_pkg::ST_HOLD: begin
        if (!brownoutSync) begin
          next_state = reset_vector_pkg::ST_LATCH;
        end
      end
      reset_vector_pkg::ST_LATCH: begin
        next_state = brownoutSync ? reset_vector_pkg::ST_HOLD : reset_vector_pkg::ST_RUN;
      end
      reset_vector_pkg::ST_RUN: begin
        if (brownoutSync || wdtFire) begin
          next_state = reset_vector_pkg::ST_HOLD; // see [RULE2]
        end
      end
      default: begin
        next_state = reset_vector_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= reset_vector_pkg::ST_HOLD; // see [RULE2]
    end else begin
      state <= next_state;
    end
  end

  assign coreHold = !running; // see [RULE1]

  // Option cell, reachable only through the programmer port
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      optionCell <= reset_vector_pkg::OPT_ERASED;
    end else if (progWrite) begin
      optionCell <= progWdata; // see [RULE16]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      progRdata <= 16'h0000;
    end else begin
      progRdata <= optionCell; // see [RULE16]
    end
  end

  // Latch option fields once per reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      options <= '0;
    end else if (state == reset_vector_pkg::ST_LATCH) begin
      options <= reset_vector_pkg::options_t'(optionCell[7:0]); // see [RULE17] [RULE9]
      if (optionCell[4:3] == 2'h3) begin
        options.brownoutThresholdSelect <= reset_vector_pkg::BOR_2V6; // see [RULE12]
      end
    end
  end

  assign progPinsReleased = !options.progPinDedicate; // see [RULE13]

  // Code protection readout
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scramble <= reset_vector_pkg::SCRAMBLE_SEED;
    end else begin
      scramble <= {scramble[14:0], scramble[15] ^ scramble[13] ^ scramble[12] ^ scramble[10]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      progFlashData <= 16'h0000;
    end else if (progFlashRead) begin
      progFlashData <= options.codeProtect ? scramble : flashRdata; // see [RULE11]
    end
  end

  // Pin routing; USART takes port A bits 3/4 ahead of capture/PWM
  always_comb begin
    pinDrive  = '0;
    pinEnable = '0;
    if (options.usartOnPortA) begin
      pinDrive.portaBit3  = usartTx; // see [RULE14]
      pinEnable.portaBit3 = 1'b1;
    end else begin
      pinDrive.portcBit0  = usartTx; // see [RULE14]
      pinEnable.portcBit0 = 1'b1;
    end
    if (options.capturePinRoute && !options.usartOnPortA) begin
      pinDrive.portaBit3  = pwmOut[1]; // see [RULE15]
      pinDrive.portaBit4  = pwmOut[0];
      pinEnable.portaBit3 = 1'b1;
      pinEnable.portaBit4 = 1'b1;
    end else if (!options.capturePinRoute) begin
      pinDrive.portbBit1  = pwmOut[0]; // see [RULE15]
      pinDrive.portbBit0  = pwmOut[1];
      pinEnable.portbBit1 = 1'b1;
      pinEnable.portbBit0 = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      usartRx <= 1'b1;
    end else begin
      usartRx <= options.usartOnPortA ? syncSecond[1] : syncSecond[0]; // see [RULE14]
    end
  end

  // Interrupt acceptance, one vector for every source
  assign intTake   = running && intRequest && intEnable && !wdtFire && !brownoutSync;
  assign intAccept = intTake; // see [RULE5]

  // Return stack control
  always_comb begin
    doPush    = 1'b0;
    doPop     = 1'b0;
    pushValue = pc;
    if (intTake) begin
      doPush    = 1'b1; // see [RULE4] [RULE6]
      pushValue = pc;
    end else if (running && coreCmd.call) begin
      doPush    = 1'b1;
      pushValue = pc + reset_vector_pkg::PC_ONE;
    end else if (running && (coreCmd.ret || coreCmd.retInt)) begin
      doPop = 1'b1;
    end
  end

  assign popValue = stackMem[stackPtr - 3'h1];

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      stackMem[stackPtr] <= pushValue; // see [RULE7]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !running) begin
      stackPtr   <= 3'h0;
      stackDepth <= 4'h0;
    end else if (doPush) begin
      stackPtr <= stackPtr + 3'h1; // see [RULE7]
      if (stackDepth != reset_vector_pkg::STACK_FULL) begin
        stackDepth <= stackDepth + 4'h1;
      end
    end else if (doPop) begin
      stackPtr <= stackPtr - 3'h1;
      if (stackDepth != 4'h0) begin
        stackDepth <= stackDepth - 4'h1;
      end
    end
  end

  // Program counter, 13 bits wrap at the top of the 8K space
  always_ff @(posedge ref_clk) begin
    if (srst || !running) begin
      pc <= reset_vector_pkg::RESET_VECTOR; // see [RULE1] [RULE8]
    end else if (intTake) begin
      pc <= reset_vector_pkg::INT_VECTOR; // see [RULE4] [RULE5]
    end else if (coreCmd.call || coreCmd.jump) begin
      pc <= coreCmd.target;
    end else if (doPop) begin
      pc <= popValue;
    end else if (coreCmd.step) begin
      pc <= pc + reset_vector_pkg::PC_ONE; // see [RULE8]
    end
  end

  // Reset kind flags
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timeoutFlag   <= 1'b1; // see [RULE3]
      powerdownFlag <= 1'b1;
      resetCause    <= reset_vector_pkg::CAUSE_POWERON;
    end else if (wdtFire) begin
      timeoutFlag <= 1'b0; // see [RULE3]
      resetCause  <= reset_vector_pkg::CAUSE_WDT;
    end else if (running && brownoutSync) begin
      timeoutFlag   <= 1'b1;
      powerdownFlag <= 1'b1;
      resetCause    <= reset_vector_pkg::CAUSE_BOR;
    end else if (wdtClear) begin
      timeoutFlag   <= 1'b1;
      powerdownFlag <= 1'b1;
    end else if (sleepEntry) begin
      powerdownFlag <= 1'b0; // see [RULE3]
    end
  end

  // Bus handshake: one wait cycle then answer
  assign busFirst        = (avs_read || avs_write) && !busAck;
  assign avs_waitrequest = busFirst;
  assign busWrite        = avs_write && busAck;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= busFirst;
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (avs_address)
      reset_vector_pkg::REG_CTRL:       readMux[reset_vector_pkg::CTRL_INT_EN] = intEnable;
      reset_vector_pkg::REG_STATUS: begin
        readMux[reset_vector_pkg::STATUS_TIMEOUT]   = timeoutFlag;
        readMux[reset_vector_pkg::STATUS_POWERDOWN] = powerdownFlag;
        readMux[reset_vector_pkg::STATUS_CAUSE_LO +: 3] = resetCause;
        readMux[reset_vector_pkg::STATUS_DEPTH_LO +: 4] = stackDepth;
      end
      reset_vector_pkg::REG_PC:         readMux[12:0] = pc;
      reset_vector_pkg::REG_IRQ_STATUS: readMux[3:0]  = irqStatus;
      reset_vector_pkg::REG_IRQ_MASK:   readMux[3:0]  = irqMask;
      default:                          readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (busFirst && avs_read) begin
      avs_readdata <= readMux;
    end
  end

  // Interrupt enable: hardware clears on entry, sets on return from interrupt
  always_ff @(posedge ref_clk) begin
    if (srst || !running) begin
      intEnable <= reset_vector_pkg::INT_EN_RST;
    end else if (intTake) begin
      intEnable <= 1'b0;
    end else if (doPop && coreCmd.retInt) begin
      intEnable <= 1'b1;
    end else if (busWrite && avs_address == reset_vector_pkg::REG_CTRL) begin
      intEnable <= avs_writedata[reset_vector_pkg::CTRL_INT_EN];
    end
  end

  // Sticky events, set wins over write-one-to-clear
  always_comb begin
    events = 4'h0;
    events[reset_vector_pkg::EV_RESET]     = state == reset_vector_pkg::ST_LATCH;
    events[reset_vector_pkg::EV_OVERFLOW]  = doPush && stackDepth == reset_vector_pkg::STACK_FULL;
    events[reset_vector_pkg::EV_UNDERFLOW] = doPop && stackDepth == 4'h0;
    events[reset_vector_pkg::EV_INT_ENTRY] = intTake;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqStatus <= 4'h0;
    end else if (busWrite && avs_address == reset_vector_pkg::REG_IRQ_STATUS) begin
      irqStatus <= (irqStatus & ~avs_writedata[3:0]) | events;
    end else begin
      irqStatus <= irqStatus | events;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqMask <= reset_vector_pkg::IRQ_MASK_RST;
    end else if (busWrite && avs_address == reset_vector_pkg::REG_IRQ_MASK) begin
      irqMask <= avs_writedata[3:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

endmodule

// ---- hdl/reset_vector_pkg.sv ----
// Constants, field layouts and carrier types for the reset and interrupt vectoring block.
// Assumes one core clock and a synchronous active-high reset.
package reset_vector_pkg;

  // Program counter and stack
  localparam int          PC_W          = 13;
  localparam logic [12:0] RESET_VECTOR  = 13'h0000;
  localparam logic [12:0] INT_VECTOR    = 13'h0004;
  localparam logic [12:0] PC_LAST       = 13'h1fff;
  localparam logic [12:0] PC_ONE        = 13'h0001;
  localparam int          STACK_DEPTH   = 8;
  localparam int          STACK_PTR_W   = 3;
  localparam logic [3:0]  STACK_FULL    = 4'h8;

  // Option word
  localparam logic [15:0] OPT_ERASED    = 16'h0000;
  localparam logic [1:0]  BOR_1V8       = 2'h0;
  localparam logic [1:0]  BOR_2V0       = 2'h1;
  localparam logic [1:0]  BOR_2V6       = 2'h2;

  // Register byte offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_PC         = 8'h08;
  localparam logic [7:0]  REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h10;

  // Field positions
  localparam int CTRL_INT_EN      = 0;
  localparam int STATUS_TIMEOUT   = 0;
  localparam int STATUS_POWERDOWN = 1;
  localparam int STATUS_CAUSE_LO  = 2;
  localparam int STATUS_DEPTH_LO  = 5;
  localparam int EV_RESET         = 0;
  localparam int EV_OVERFLOW      = 1;
  localparam int EV_UNDERFLOW     = 2;
  localparam int EV_INT_ENTRY     = 3;
  localparam int EV_W             = 4;

  // Reset values
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
  localparam logic        INT_EN_RST    = 1'b0;
  localparam logic [2:0]  CAUSE_POWERON = 3'h1;
  localparam logic [2:0]  CAUSE_WDT     = 3'h2;
  localparam logic [2:0]  CAUSE_BOR     = 3'h4;
  localparam logic [15:0] SCRAMBLE_SEED = 16'hace1;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_LATCH = 3'b010,
    ST_RUN   = 3'b100
  } seq_state_t;

  // Decoded option fields, lowest member is bit 0 of the option word
  typedef struct packed {
    logic       capturePinRoute;
    logic       usartOnPortA;
    logic       progPinDedicate;
    logic [1:0] brownoutThresholdSelect;
    logic       codeProtect;
    logic       wdtEnable;
    logic       oscFreqSelect;
  } options_t;

  // Program flow requests from the core
  typedef struct packed {
    logic        step;
    logic        jump;
    logic        call;
    logic        ret;
    logic        retInt;
    logic [12:0] target;
  } core_cmd_t;

  // One bit per routed pin
  typedef struct packed {
    logic portaBit3;
    logic portaBit4;
    logic portbBit0;
    logic portbBit1;
    logic portcBit0;
    logic portcBit1;
  } pins_t;

endpackage

// ---- testbench/rivc_asserts.sv ----
// Port checks for the vectoring block.
// Bound into the block; one clock, synchronous reset.
`timescale 1ns/1ps
module rivc_asserts (
  input wire logic                       ref_clk,
  input wire logic                       srst,
  input wire logic                       wdtTimeout,
  input wire logic                       brownoutTrip,
  input wire logic                       intRequest,
  input wire logic [12:0]                pc,
  input wire logic                       coreHold,
  input wire logic                       intAccept,
  input wire reset_vector_pkg::options_t options,
  input wire logic                       progPinsReleased,
  input wire logic                       progFlashRead,
  input wire logic [15:0]                flashRdata,
  input wire logic [15:0]                progFlashData,
  input wire logic                       usartTx,
  input wire reset_vector_pkg::pins_t    pinDrive
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  sequence releaseSeq;
    $fell(srst);
  endsequence
  sequence tripSeq;
    brownoutTrip [*4];
  endsequence
  sequence entrySeq;
    intAccept ##1 (pc == 13'h0004);
  endsequence
  reset_start_a: assert property (releaseSeq |-> pc == 13'h0000 && coreHold)
    else $error("pc not at reset vector on release");
  int_vector_a: assert property (intAccept |-> entrySeq)
    else $error("interrupt entry missed vector");
  int_cause_a: assert property (intAccept |-> intRequest && !coreHold)
    else $error("interrupt taken without request");
  wdt_reset_a: assert property (wdtTimeout && options.wdtEnable && !coreHold
    |-> ##[1:3] (coreHold && pc == 13'h0000))
    else $error("watchdog did not reset");
  wdt_off_a: assert property (wdtTimeout && !options.wdtEnable && !coreHold && !brownoutTrip
    |=> !coreHold)
    else $error("disabled watchdog reset the core");
  bor_reset_a: assert property (tripSeq |-> ##[0:3] (coreHold && pc == 13'h0000))
    else $error("brownout did not reset");
  opt_hold_a: assert property (!coreHold && !$past(coreHold) |-> $stable(options))
    else $error("options changed while running");
  prog_pins_a: assert property (!coreHold |-> progPinsReleased == !options.progPinDedicate)
    else $error("programming pin release wrong");
  flash_plain_a: assert property (progFlashRead && !options.codeProtect
    |=> progFlashData == $past(flashRdata))
    else $error("unprotected flash read wrong");
  flash_hide_a: assert property (progFlashRead && options.codeProtect
    |=> progFlashData != $past(flashRdata))
    else $error("protected flash read leaked");
  usart_route_a: assert property (usartTx && !coreHold
    |-> (options.usartOnPortA ? pinDrive.portaBit3 : pinDrive.portcBit0))
    else $error("transmit pin not routed");
endmodule

bind reset_interrupt_vectoring_config rivc_asserts i_chk (
  .ref_clk, .srst, .wdtTimeout, .brownoutTrip, .intRequest, .pc, .coreHold, .intAccept,
  .options, .progPinsReleased, .progFlashRead, .flashRdata, .progFlashData, .usartTx,
  .pinDrive
);

// ---- testbench/prog_irq_model.sv ----
// Interrupt sources and option programmer on the block's far side.
// Driven by task calls from the bench, on ref_clk edges.
`timescale 1ns/1ps
module prog_irq_model #(
  parameter logic [15:0] FLASH_WORD = 16'h3c5a
) (
  input  wire logic   ref_clk,
  output logic        intRequest,
  output logic        progWrite,
  output logic [15:0] progWdata,
  output logic        progFlashRead,
  output logic [15:0] flashRdata
);
  logic [2:0] src;
  initial begin
    src = 3'h0;
    progWrite = 1'b0;
    progWdata = 16'hffff;
    progFlashRead = 1'b0;
  end
  // Sources share one request line
  assign intRequest = |src;
  // Idle data shows the inverse pattern
  assign flashRdata = progFlashRead ? FLASH_WORD : ~FLASH_WORD;
  task raise(input int i);
    src[i] <= 1'b1;
  endtask
  task drop;
    src <= 3'h0;
  endtask
  // Only this side writes the option word
  task burn(input logic [15:0] w);
    progWdata <= w;
    progWrite <= 1'b1;
    @(posedge ref_clk);
    progWrite <= 1'b0;
    progWdata <= ~w;
    @(posedge ref_clk);
  endtask
  task readFlash;
    progFlashRead <= 1'b1;
    @(posedge ref_clk);
    progFlashRead <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the vectoring block.
// Checker binds itself; partner model drives sources and programmer.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] FLASH_WORD = 16'h3c5a;
  localparam logic [4:0]  JMP = 5'h08;
  localparam logic [4:0]  CAL = 5'h04;
  localparam logic [4:0]  RET = 5'h02;
  localparam logic [4:0]  RTI = 5'h01;
  logic                        ref_clk = 1'b0;
  logic                        srst = 1'b1;
  logic                        wdtTimeout = 1'b0;
  logic                        brownoutTrip = 1'b0;
  logic                        sleepEntry = 1'b0;
  logic                        wdtClear = 1'b0;
  logic                        rxPin = 1'b1;
  reset_vector_pkg::core_cmd_t coreCmd = '0;
  logic [7:0]                  avs_address = 8'h00;
  logic                        avs_read = 1'b0;
  logic                        avs_write = 1'b0;
  logic [31:0]                 avs_writedata = 32'h0;
  logic [31:0]                 rdata;
  int                          errCount = 0;
  int                          samplesChecked = 0;
  wire logic [12:0]            pc;
  wire logic                   coreHold, intAccept, intRequest, progPinsReleased, irq;
  wire logic                   progWrite, progFlashRead, avs_waitrequest, usartRx;
  wire logic [15:0]            progWdata, progRdata, flashRdata, progFlashData;
  wire logic [31:0]            avs_readdata;
  reset_vector_pkg::options_t  options;
  reset_vector_pkg::pins_t     pinDrive;

  always #50 ref_clk = ~ref_clk;

  prog_irq_model #(.FLASH_WORD(FLASH_WORD)) i_model (.ref_clk(ref_clk),
    .intRequest(intRequest), .progWrite(progWrite), .progWdata(progWdata),
    .progFlashRead(progFlashRead), .flashRdata(flashRdata));

  reset_interrupt_vectoring_config i_dut (.ref_clk(ref_clk), .srst(srst),
    .wdtTimeout(wdtTimeout), .brownoutTrip(brownoutTrip), .sleepEntry(sleepEntry),
    .wdtClear(wdtClear), .coreCmd(coreCmd), .intRequest(intRequest), .pc(pc),
    .coreHold(coreHold), .intAccept(intAccept), .options(options),
    .progPinsReleased(progPinsReleased), .progWrite(progWrite), .progWdata(progWdata),
    .progRdata(progRdata), .progFlashRead(progFlashRead), .flashRdata(flashRdata),
    .progFlashData(progFlashData), .usartTx(1'b1), .usartRx(usartRx), .pwmOut(2'h2),
    .portaBit4In(rxPin), .portcBit1In(!rxPin), .pinDrive(pinDrive), .pinEnable(),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));

  task conclude;
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata;
    if (n >= 20) chk(32'h1, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  task automatic cmd(input logic [4:0] k, input logic [12:0] t);
    coreCmd <= reset_vector_pkg::core_cmd_t'({k, t});
    @(posedge ref_clk);
    coreCmd <= '0;
    @(posedge ref_clk);
  endtask

  task automatic waitRun;
    int n;
    n = 0;
    while (coreHold !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20) chk(32'h1, 32'h0);
  endtask

  task t_reset;
    chk(32'(pc), 32'h0);
    rd(reset_vector_pkg::REG_STATUS, 32'h7);
    rd(reset_vector_pkg::REG_CTRL, 32'h0);
    rd(reset_vector_pkg::REG_IRQ_STATUS, 32'h1);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'b1, reset_vector_pkg::REG_IRQ_MASK, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b1, reset_vector_pkg::REG_IRQ_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    rd(reset_vector_pkg::REG_IRQ_MASK, 32'h1);
    sleepEntry <= 1'b1;
    @(posedge ref_clk);
    sleepEntry <= 1'b0;
    rd(reset_vector_pkg::REG_STATUS, 32'h5);
    wdtClear <= 1'b1;
    @(posedge ref_clk);
    wdtClear <= 1'b0;
    rd(reset_vector_pkg::REG_STATUS, 32'h7);
  endtask

  // Every source lands on the one vector
  task t_int;
    int n;
    bus(1'b1, reset_vector_pkg::REG_CTRL, 32'h1);
    cmd(CAL, 13'h0123);
    for (int i = 0; i < 3; i++) begin
      i_model.raise(i);
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (intAccept !== 1'b1 && n < 20);
      i_model.drop();
      @(posedge ref_clk);
      chk(32'(pc), 32'h4);
      rd(reset_vector_pkg::REG_STATUS, 32'h47);
      rd(reset_vector_pkg::REG_CTRL, 32'h0);
      cmd(RTI, 13'h0);
      chk(32'(pc), 32'h123);
    end
    cmd(RET, 13'h0);
    chk(32'(pc), 32'h1);
  endtask

  // Ninth call overwrites the oldest entry
  task t_stack;
    bus(1'b1, reset_vector_pkg::REG_IRQ_MASK, 32'h2);
    for (int i = 0; i < 8; i++) cmd(CAL, 13'(16 * i));
    rd(reset_vector_pkg::REG_STATUS, 32'h107);
    chk(32'(irq), 32'h0);
    cmd(CAL, reset_vector_pkg::PC_LAST);
    chk(32'(pc), 32'h1fff);
    chk(32'(irq), 32'h1);
    rd(reset_vector_pkg::REG_STATUS, 32'h107);
    bus(1'b1, reset_vector_pkg::REG_IRQ_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
    for (int i = 0; i < 8; i++) cmd(RET, 13'h0);
    chk(32'(pc), 32'h1);
  endtask

  task automatic t_opt(input logic [15:0] w);
    i_model.burn(w);
    @(posedge ref_clk);
    chk(32'(progRdata), 32'(w));
    brownoutTrip <= 1'b1;
    repeat (4) @(posedge ref_clk);
    brownoutTrip <= 1'b0;
    waitRun();
    chk(32'(pc), 32'h0);
    rd(reset_vector_pkg::REG_STATUS, 32'h13);
    chk(32'(options), 32'(w[7:0]));
    chk(32'(progPinsReleased), 32'(!w[5]));
    chk(32'(w[6] ? pinDrive.portaBit3 : pinDrive.portcBit0), 32'h1);
    chk(32'(usartRx), 32'(w[6]));
    chk(32'(w[7] ? {pinDrive.portaBit3, pinDrive.portaBit4}
      : {pinDrive.portbBit0, pinDrive.portbBit1}), 32'h2);
    i_model.readFlash();
    chk(32'(progFlashData === FLASH_WORD), 32'(!w[2]));
    i_model.burn(~w);
    chk(32'(options), 32'(w[7:0]));
    cmd(JMP, 13'h0055);
    wdtTimeout <= 1'b1;
    @(posedge ref_clk);
    wdtTimeout <= 1'b0;
    @(posedge ref_clk);
    waitRun();
    chk(32'(pc), w[1] ? 32'h0 : 32'h55);
    rd(reset_vector_pkg::REG_STATUS, w[1] ? 32'ha : 32'h13);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    waitRun();
    t_reset();
    t_int();
    t_stack();
    t_opt(16'h5ab5);
    t_opt(16'h034a);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    conclude();
  end
endmodule
